// ===== shared/cid_pkg.sv
// Shared constants for the compact instruction decode and execute block.
`default_nettype none
package cid_pkg;
    // ------------------------------------------------------------------
    // Group opcode patterns and field positions.
    // ------------------------------------------------------------------
    localparam logic [5:0] HIREG_PAT   = 6'h11;
    localparam logic [4:0] PCREL_PAT   = 5'h09;
    localparam logic [3:0] REGOFF_PAT  = 4'h5;
    localparam int         FUNC_LSB    = 8;
    localparam int         DEST_HI_BIT = 7;
    localparam int         SRC_HI_BIT  = 6;
    localparam int         SEXT_SEL    = 9;
    localparam int         LOAD_BIT    = 11;
    localparam int         BYTE_BIT    = 10;
    localparam int         SIGN_BIT    = 10;
    localparam int         HALF_BIT    = 11;
    // ------------------------------------------------------------------
    // Function codes of the hi-register group.
    // ------------------------------------------------------------------
    localparam logic [1:0] FC_ADD = 2'h0;
    localparam logic [1:0] FC_CMP = 2'h1;
    localparam logic [1:0] FC_MOV = 2'h2;
    localparam logic [1:0] FC_BX  = 2'h3;
    // ------------------------------------------------------------------
    // Access sizes and program counter constants.
    // ------------------------------------------------------------------
    localparam logic [1:0] SZ_BYTE = 2'h0;
    localparam logic [1:0] SZ_HALF = 2'h1;
    localparam logic [1:0] SZ_WORD = 2'h2;
    localparam logic [3:0] PC_IDX  = 4'hF;
    localparam logic [31:0] PC_AHEAD = 32'h0000_0004;
    // ------------------------------------------------------------------
    // Cycle counts, equal to the full-width equivalents.
    // ------------------------------------------------------------------
    localparam logic [1:0] CYC_DATA  = 2'h1;
    localparam logic [1:0] CYC_PCWR  = 2'h3;
    localparam logic [1:0] CYC_LOAD  = 2'h3;
    localparam logic [1:0] CYC_STORE = 2'h2;
    localparam logic [1:0] CYC_UNDEF = 2'h1;
    localparam logic       RST_COMPRESSED = 1'b1;
    typedef enum logic [2:0] {
        ST_IDLE = 3'h1,
        ST_EXEC = 3'h2,
        ST_HOLD = 3'h4
    } cid_state_t;
endpackage : cid_pkg
`default_nettype wire

// ===== src/cid_regfile.sv
// Sixteen-word register file with three registered read ports.
`default_nettype none
module cid_regfile (
    // Clock.
    input  wire logic        core_clk_i,
    // Read addresses and data.
    input  wire logic [3:0]  rd_a_idx_i,
    input  wire logic [3:0]  rd_b_idx_i,
    input  wire logic [3:0]  rd_c_idx_i,
    output logic      [31:0] rd_a_o,
    output logic      [31:0] rd_b_o,
    output logic      [31:0] rd_c_o,
    // Write port.
    input  wire logic        wr_en_i,
    input  wire logic [3:0]  wr_idx_i,
    input  wire logic [31:0] wr_data_i
);
    logic [31:0] mem_ff [16];

    always_ff @(posedge core_clk_i) begin
        if (wr_en_i) begin
            mem_ff[wr_idx_i] <= wr_data_i;
        end
        rd_a_o <= mem_ff[rd_a_idx_i];
        rd_b_o <= mem_ff[rd_b_idx_i];
        rd_c_o <= mem_ff[rd_c_idx_i];
    end
endmodule // cid_regfile
`default_nettype wire

// ===== src/cid_load_ext.sv
// Lane selection and zero or sign extension of loaded data.
`default_nettype none
module cid_load_ext
    import cid_pkg::*;
(
    // Clock and reset.
    input  wire logic        core_clk_i,
    input  wire logic        reset_i,
    // Raw load data and its description.
    input  wire logic        capture_i,
    input  wire logic [31:0] rdata_i,
    input  wire logic [1:0]  lane_i,
    input  wire logic [1:0]  size_i,
    input  wire logic        signed_i,
    // Extended result.
    output logic      [31:0] data_o
);
    logic [31:0] data_ff;
    wire  [31:0] shifted = rdata_i >> {lane_i, 3'h0};
    wire         byte_msb = shifted[7];
    wire         half_msb = shifted[15];
    wire  [31:0] byte_ext = {{24{signed_i & byte_msb}}, shifted[7:0]};
    wire  [31:0] half_ext = {{16{signed_i & half_msb}}, shifted[15:0]};
    wire  [31:0] nxt_data = (size_i == SZ_BYTE) ? byte_ext :
                            (size_i == SZ_HALF) ? half_ext : rdata_i;

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            data_ff <= 32'h0000_0000;
        end else if (capture_i) begin
            data_ff <= nxt_data; // RULE17 RULE18 RULE19
        end
    end
    assign data_o = data_ff;
endmodule // cid_load_ext
`default_nettype wire

// ===== src/cid_exec.sv
// Decode and execute of the hi-register, pc-relative and load/store groups.
//
// Functional notes
// (RULE1) Codes 00,01,10: add, compare, move.
// (RULE2) Only compare updates status register flags.
// (RULE3) Software avoids both high flags clear.
// (RULE4) Set high flag selects registers 8-15.
// (RULE5) Code 11 branches to selected register.
// (RULE6) Target bit 0 selects the new state.
// (RULE7) Software never sets dest flag in exchange.
// (RULE8) Register 15 reads address+4, bit0 cleared.
// (RULE9) Software avoids misaligned branch-exchange on pc.
// (RULE10) Cycle counts match full-width equivalents.
// (RULE11) Pc-relative load adds unsigned word offset.
// (RULE12) Offset field shifted left by two.
// (RULE13) Pc base is address+4, bit1 cleared.
// (RULE14) Address is base plus offset register.
// (RULE15) Load/byte flags select word/byte access.
// (RULE16) Pair 00 stores low halfword.
// (RULE17) Pair 01 loads zero-extended halfword.
// (RULE18) Pair 10 loads sign-extended byte.
// (RULE19) Pair 11 loads sign-extended halfword.
// (RULE20) Undefined encodings are flagged, not executed.
`default_nettype none
module cid_exec
    import cid_pkg::*;
(
    // Clock and reset.
    input  wire logic        core_clk_i,
    input  wire logic        reset_i,
    // Instruction issue.
    input  wire logic        issue_valid_i,
    input  wire logic [15:0] instr_i,
    input  wire logic [31:0] instr_addr_i,
    output logic             ready_o,
    output logic             done_o,
    output logic             undef_o,
    // Status flags and program flow.
    output logic      [3:0]  flags_o,
    output logic             flags_we_o,
    output logic             branch_o,
    output logic      [31:0] branch_target_o,
    output logic             compressed_state_o,
    // Memory access.
    input  wire logic [31:0] mem_rdata_i,
    output logic             mem_req_o,
    output logic             mem_we_o,
    output logic      [1:0]  mem_size_o,
    output logic      [31:0] mem_addr_o,
    output logic      [31:0] mem_wdata_o
);
    // ------------------------------------------------------------------
    // State and registered outputs.
    // ------------------------------------------------------------------
    cid_state_t  state_ff, nxt_state;
    logic [15:0] instr_ff;
    logic [31:0] addr_ff;
    logic [1:0]  cnt_ff;
    logic        ready_ff, done_ff, undef_ff, flags_we_ff, branch_ff;
    logic        comp_ff, req_ff, we_ff, cap_ff, sign_ff, load_ff;
    logic [3:0]  flags_ff, ld_idx_ff;
    logic [1:0]  size_ff;
    logic [31:0] target_ff, maddr_ff, wdata_ff;

    // ------------------------------------------------------------------
    // Read-side decode on the incoming instruction.
    // ------------------------------------------------------------------
    wire in_hireg = instr_i[15:10] == HIREG_PAT;
    wire [3:0] rd_a_idx = in_hireg ? {instr_i[DEST_HI_BIT], instr_i[2:0]}
                                   : {1'b0, instr_i[5:3]}; // RULE4
    wire [3:0] rd_b_idx = in_hireg ? {instr_i[SRC_HI_BIT], instr_i[5:3]}
                                   : {1'b0, instr_i[8:6]}; // RULE4 RULE14
    wire [3:0] rd_c_idx = {1'b0, instr_i[2:0]};
    wire       take     = issue_valid_i & ready_ff;

    logic [3:0]  ra_ff, rb_ff;
    wire  [31:0] rf_a, rf_b, rf_c, ext_data;

    // ------------------------------------------------------------------
    // Execute-side decode on the held instruction.
    // ------------------------------------------------------------------
    wire       is_hireg  = instr_ff[15:10] == HIREG_PAT;
    wire       is_pcrel  = instr_ff[15:11] == PCREL_PAT;
    wire       is_regoff = instr_ff[15:12] == REGOFF_PAT;
    wire       is_sext   = is_regoff & instr_ff[SEXT_SEL];
    wire       is_word7  = is_regoff & ~instr_ff[SEXT_SEL];
    wire [1:0] func      = instr_ff[FUNC_LSB +: 2];
    wire       dhi       = instr_ff[DEST_HI_BIT];
    wire       shi       = instr_ff[SRC_HI_BIT];
    wire       is_bx     = is_hireg & (func == FC_BX);
    wire       undef_hi  = is_hireg & ~is_bx & ~dhi & ~shi; // RULE20
    wire       undef_bx  = is_bx & dhi; // RULE20
    wire       undef_any = undef_hi | undef_bx | ~(is_hireg | is_pcrel
                                                   | is_regoff);
    wire       pair_sign = instr_ff[SIGN_BIT];
    wire       pair_half = instr_ff[HALF_BIT];
    wire       w7_load   = instr_ff[LOAD_BIT];
    wire       w7_byte   = instr_ff[BYTE_BIT];

    // Register 15 reads as the instruction address plus four.
    wire [31:0] pc_ahead = addr_ff + PC_AHEAD;
    wire [31:0] pc_read  = pc_ahead & 32'hFFFF_FFFE; // RULE8
    wire [31:0] pc_word  = pc_ahead & 32'hFFFF_FFFD; // RULE13
    wire [31:0] opnd_a   = (ra_ff == PC_IDX) ? pc_read : rf_a; // RULE8
    wire [31:0] opnd_b   = (rb_ff == PC_IDX) ? pc_read : rf_b; // RULE8
    wire [31:0] imm_off  = {22'h0, instr_ff[7:0], 2'h0}; // RULE12

    // Hi-register arithmetic and compare flags.
    wire [31:0] sum      = opnd_a + opnd_b;
    wire [32:0] diff     = {1'b0, opnd_a} - {1'b0, opnd_b};
    wire        cmp_v    = (opnd_a[31] ^ opnd_b[31]) & (opnd_a[31] ^ diff[31]);
    wire [3:0]  cmp_nzcv = {diff[31], diff[31:0] == 32'h0, ~diff[32], cmp_v};
    wire        is_cmp   = is_hireg & (func == FC_CMP) & ~undef_hi;
    wire        hi_wr    = is_hireg & ~undef_hi & (func == FC_ADD
                                                   | func == FC_MOV); // RULE1
    wire [31:0] hi_res   = (func == FC_ADD) ? sum : opnd_b; // RULE1
    wire [3:0]  hi_dst   = {dhi, instr_ff[2:0]};
    wire        pc_write = hi_wr & (hi_dst == PC_IDX);

    // Memory request decode.
    wire        mem_load = is_pcrel | (is_word7 & w7_load)
                           | (is_sext & (pair_sign | pair_half)); // RULE15
    wire        mem_any  = (is_pcrel | is_regoff) & ~undef_any;
    wire [31:0] ea       = is_pcrel ? pc_word + imm_off
                                    : opnd_a + opnd_b; // RULE11 RULE14
    wire [1:0]  ea_size  = is_pcrel ? SZ_WORD :
                           is_word7 ? (w7_byte ? SZ_BYTE : SZ_WORD) // RULE15
                                    : ((~pair_sign | pair_half) ? SZ_HALF
                                                                : SZ_BYTE);
    wire [31:0] st_data  = (ea_size == SZ_HALF) ? {16'h0, rf_c[15:0]} // RULE16
                         : (ea_size == SZ_BYTE) ? {24'h0, rf_c[7:0]}
                                                : rf_c;
    wire [3:0]  ld_idx   = is_pcrel ? {1'b0, instr_ff[10:8]}
                                    : {1'b0, instr_ff[2:0]};
    wire [1:0]  cyc_sel  = undef_any ? CYC_UNDEF :
                           (is_bx | pc_write) ? CYC_PCWR :
                           mem_any ? (mem_load ? CYC_LOAD : CYC_STORE)
                                   : CYC_DATA; // RULE10

    // Register file write: hi-group results now, loads at the last hold.
    wire        exec     = state_ff == ST_EXEC;
    wire        last     = (state_ff == ST_HOLD) & (cnt_ff == 2'h1);
    wire        wr_hi    = exec & hi_wr & ~pc_write;
    wire        wr_ld    = last & load_ff;
    wire        wr_en    = wr_hi | wr_ld;
    wire [3:0]  wr_idx   = wr_ld ? ld_idx_ff : hi_dst;
    wire [31:0] wr_data  = wr_ld ? ext_data : hi_res;

    cid_regfile u_regfile (
        .core_clk_i (core_clk_i),
        .rd_a_idx_i (rd_a_idx),
        .rd_b_idx_i (rd_b_idx),
        .rd_c_idx_i (rd_c_idx),
        .rd_a_o     (rf_a),
        .rd_b_o     (rf_b),
        .rd_c_o     (rf_c),
        .wr_en_i    (wr_en),
        .wr_idx_i   (wr_idx),
        .wr_data_i  (wr_data)
    );

    cid_load_ext u_load_ext (
        .core_clk_i (core_clk_i),
        .reset_i    (reset_i),
        .capture_i  (cap_ff),
        .rdata_i    (mem_rdata_i),
        .lane_i     (maddr_ff[1:0]),
        .size_i     (size_ff),
        .signed_i   (sign_ff),
        .data_o     (ext_data)
    );

    // ------------------------------------------------------------------
    // Sequencer.
    // ------------------------------------------------------------------
    always_comb begin
        case (state_ff)
            ST_IDLE: nxt_state = take ? ST_EXEC : ST_IDLE;
            ST_EXEC: nxt_state = ST_HOLD;
            ST_HOLD: nxt_state = (cnt_ff == 2'h1) ? ST_IDLE : ST_HOLD;
            default: nxt_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            state_ff <= ST_IDLE;
            cnt_ff   <= 2'h0;
            ready_ff <= 1'b0;
            done_ff  <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            cnt_ff   <= exec ? cyc_sel : cnt_ff - 2'h1; // RULE10
            ready_ff <= nxt_state == ST_IDLE;
            done_ff  <= last; // RULE10
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (take) begin
            instr_ff <= instr_i;
            addr_ff  <= instr_addr_i;
            ra_ff    <= rd_a_idx;
            rb_ff    <= rd_b_idx;
        end
        if (exec) begin
            ld_idx_ff <= ld_idx;
            size_ff   <= ea_size;
            sign_ff   <= is_sext & pair_sign; // RULE18 RULE19
            maddr_ff  <= ea;
            wdata_ff  <= st_data;
            target_ff <= (is_bx ? opnd_b : hi_res) & 32'hFFFF_FFFE; // RULE5
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            undef_ff    <= 1'b0;
            flags_ff    <= 4'h0;
            flags_we_ff <= 1'b0;
            branch_ff   <= 1'b0;
            comp_ff     <= RST_COMPRESSED;
            req_ff      <= 1'b0;
            we_ff       <= 1'b0;
            cap_ff      <= 1'b0;
            load_ff     <= 1'b0;
        end else begin
            undef_ff    <= last & undef_any;
            flags_we_ff <= exec & is_cmp; // RULE2
            if (exec & is_cmp) begin
                flags_ff <= cmp_nzcv; // RULE2
            end
            branch_ff   <= exec & ((is_bx & ~undef_bx) | pc_write); // RULE5
            if (exec & is_bx & ~undef_bx) begin
                comp_ff <= opnd_b[0]; // RULE6
            end
            req_ff      <= exec & mem_any;
            we_ff       <= exec & mem_any & ~mem_load;
            cap_ff      <= req_ff & ~we_ff;
            load_ff     <= exec ? (mem_any & mem_load) : load_ff;
        end
    end

    assign ready_o            = ready_ff;
    assign done_o             = done_ff;
    assign undef_o            = undef_ff;
    assign flags_o            = flags_ff;
    assign flags_we_o         = flags_we_ff;
    assign branch_o           = branch_ff;
    assign branch_target_o    = target_ff;
    assign compressed_state_o = comp_ff;
    assign mem_req_o          = req_ff;
    assign mem_we_o           = we_ff;
    assign mem_size_o         = size_ff;
    assign mem_addr_o         = maddr_ff;
    assign mem_wdata_o        = wdata_ff;

    // ------------------------------------------------------------------
    // Assertions and cover points.
    // ------------------------------------------------------------------
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (reset_i);

    flags_cmp_only_a: assert property ( // RULE2
        flags_we_o |-> $past(exec & is_hireg & func == FC_CMP))
        else $error("Flags written by a non-compare instruction.");
    hi_select_a: assert property ( // RULE4
        take & in_hireg |=> ra_ff == {instr_ff[DEST_HI_BIT], instr_ff[2:0]}
                            && rb_ff == {instr_ff[SRC_HI_BIT], instr_ff[5:3]})
        else $error("High select flag not honoured.");
    bx_state_a: assert property ( // RULE6
        exec & is_bx & ~dhi |=> compressed_state_o == $past(opnd_b[0])
                                && branch_o)
        else $error("Exchange state does not follow target bit 0.");
    pc_operand_a: assert property ( // RULE8
        exec & rb_ff == PC_IDX |-> opnd_b == ((addr_ff + 32'h4) & ~32'h1))
        else $error("Register 15 operand value wrong.");
    load_cycles_a: assert property ( // RULE10
        exec & mem_any & mem_load |-> ##4 done_o)
        else $error("Load did not take its cycle count.");
    data_cycles_a: assert property ( // RULE10
        exec & hi_wr & ~pc_write & ~undef_any |-> ##1 !done_o ##1 done_o)
        else $error("Data operation did not take one cycle.");
    pcrel_addr_a: assert property ( // RULE13
        exec & is_pcrel |=> mem_addr_o[1:0] == 2'h0 && mem_req_o
            && mem_addr_o == $past(((addr_ff + 32'h4) & ~32'h2) + imm_off))
        else $error("Pc-relative address wrong.");
    regoff_addr_a: assert property ( // RULE14
        exec & is_regoff |=> mem_addr_o == $past(rf_a + rf_b))
        else $error("Register offset address wrong.");
    sext_byte_a: assert property ( // RULE18
        wr_ld & size_ff == SZ_BYTE & sign_ff
            |-> wr_data[31:8] == {24{wr_data[7]}})
        else $error("Signed byte not extended.");
    undef_flag_a: assert property ( // RULE20
        exec & undef_hi |=> !flags_we_o && !branch_o ##1 undef_o)
        else $error("Undefined encoding not flagged.");

    cmp_seen_c:   cover property (flags_we_o);
    bx_seen_c:    cover property (exec & is_bx & ~dhi);
    sload_seen_c: cover property (wr_ld & sign_ff);
    store_seen_c: cover property (mem_req_o & mem_we_o);
endmodule // cid_exec
`default_nettype wire

// ===== verification/cid_exec_tb_top.sv
// Self-checking testbench for the compact instruction decode and execute block.
`default_nettype none
module cid_exec_tb_top
    import cid_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic        core_clk_i, reset_i, issue_valid_i;
    logic [15:0] instr_i;
    logic [31:0] instr_addr_i, mem_rdata_i;
    logic        ready_o, done_o, undef_o, flags_we_o, branch_o;
    logic        compressed_state_o, mem_req_o, mem_we_o;
    logic [3:0]  flags_o, r_flags;
    logic [1:0]  mem_size_o, r_size;
    logic [31:0] branch_target_o, mem_addr_o, mem_wdata_o;
    logic [31:0] r_addr, r_wdata, r_tgt;
    logic        r_we, r_undef, r_rdy1;
    int          error_cnt, cmp_count, rq_k, fw_k, br_k, dn_k;

    initial core_clk_i = 1'h0;
    always #10 core_clk_i = ~core_clk_i;

    cid_exec dut_u (
        .core_clk_i(core_clk_i), .reset_i(reset_i),
        .issue_valid_i(issue_valid_i), .instr_i(instr_i),
        .instr_addr_i(instr_addr_i), .ready_o(ready_o), .done_o(done_o),
        .undef_o(undef_o), .flags_o(flags_o), .flags_we_o(flags_we_o),
        .branch_o(branch_o), .branch_target_o(branch_target_o),
        .compressed_state_o(compressed_state_o),
        .mem_rdata_i(mem_rdata_i), .mem_req_o(mem_req_o),
        .mem_we_o(mem_we_o), .mem_size_o(mem_size_o),
        .mem_addr_o(mem_addr_o), .mem_wdata_o(mem_wdata_o)
    );

    // ------------------------------------------------------------------
    // Reporting and encoding helpers.
    // ------------------------------------------------------------------
    task automatic end_sim();
        $display("Counts: %0d compares, %0d mismatches", cmp_count,
                 error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp,
                           input string what);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic chk_cyc(input int got, input int exp, input string what);
        cmp_count++;
        if (got != exp) begin
            error_cnt++;
            $display("BAD t=%0t %s cycle %0d exp %0d", $time, what, got, exp);
        end
    endtask

    function automatic logic [15:0] hi(input logic [1:0] fc, input logic h1,
                                       input logic h2, input logic [2:0] rs,
                                       input logic [2:0] rd);
        return {HIREG_PAT, fc, h1, h2, rs, rd};
    endfunction

    function automatic logic [15:0] ls(input logic b11, input logic b10,
                                       input logic b9, input logic [2:0] ro,
                                       input logic [2:0] rd);
        return {REGOFF_PAT, b11, b10, b9, ro, 3'h1, rd};
    endfunction

    function automatic logic [3:0] nzcv(input logic [31:0] a,
                                        input logic [31:0] b);
        logic [31:0] r;
        r = a - b;
        return {r[31], r == 32'h0, a >= b,
                (a[31] != b[31]) && (r[31] != a[31])};
    endfunction

    // Issues one instruction and records every output pulse by cycle.
    // Load data is valid only around the cycle after the request.
    task automatic run(input logic [15:0] ins, input logic [31:0] pc,
                       input logic [31:0] rdata);
        int n;
        rq_k = 0;
        fw_k = 0;
        br_k = 0;
        dn_k = 0;
        n = 0;
        @(negedge core_clk_i);
        issue_valid_i = 1'h1;
        instr_i = ins;
        instr_addr_i = pc;
        while (ready_o !== 1'h1 && n < 20) begin
            @(negedge core_clk_i);
            n++;
        end
        if (ready_o !== 1'h1) begin
            error_cnt++;
            $display("BAD t=%0t instruction never taken", $time);
            end_sim();
        end
        @(negedge core_clk_i);
        issue_valid_i = 1'h0;
        // The rising edge just passed took it; sample mid-cycle, k is the cycle.
        for (int k = 1; k <= 12 && dn_k == 0; k++) begin
            if (k == 1) r_rdy1 = ready_o;
            if (mem_req_o === 1'h1) begin
                rq_k = k;
                {r_we, r_size, r_addr} = {mem_we_o, mem_size_o, mem_addr_o};
                r_wdata = mem_wdata_o;
            end
            if (flags_we_o === 1'h1) begin
                fw_k = k;
                r_flags = flags_o;
            end
            if (branch_o === 1'h1) begin
                br_k = k;
                r_tgt = branch_target_o;
            end
            if (done_o === 1'h1) begin
                dn_k = k;
                r_undef = undef_o;
            end
            mem_rdata_i = (rq_k != 0 && k - rq_k <= 1) ? rdata : ~rdata;
            @(negedge core_clk_i);
        end
        chk_val(r_rdy1, 1'h0, "ready after take");
        if (dn_k == 0) begin
            error_cnt++;
            $display("BAD t=%0t instruction never completed", $time);
            end_sim();
        end
    endtask

    // ------------------------------------------------------------------
    // Scenario building blocks.
    // ------------------------------------------------------------------
    task automatic st(input logic [15:0] ins, input logic [31:0] addr,
                      input logic [1:0] sz, input logic [31:0] wd);
        run(ins, 32'h0, 32'h0);
        chk_val(r_addr, addr, "store address");
        chk_val({r_we, r_size}, {1'h1, sz}, "store kind");
        chk_val(r_wdata, wd, "store data");
        chk_cyc(dn_k, 4, "store cycles");
    endtask

    task automatic peek(input logic [2:0] rd, input logic [31:0] exp);
        st(ls(1'h0, 1'h0, 1'h0, 3'h2, rd), 32'h1020, SZ_WORD, exp);
    endtask

    task automatic ld(input logic [15:0] ins, input logic [31:0] rdata,
                      input logic [31:0] addr, input logic [1:0] sz,
                      input logic [31:0] val);
        run(ins, 32'h0, rdata);
        chk_val(r_addr, addr, "load address");
        chk_val({r_we, r_size}, {1'h0, sz}, "load kind");
        chk_cyc(dn_k, 5, "load cycles");
        peek(ins[2:0], val);
    endtask

    task automatic set_reg(input logic [2:0] rd, input logic [31:0] val,
                           input logic [31:0] pc, input logic [7:0] imm);
        logic [31:0] e;
        e = ((pc + 32'h4) & 32'hFFFF_FFFD) + {22'h0, imm, 2'h0};
        run({PCREL_PAT, rd, imm}, pc, val);
        chk_val(r_addr, e, "pc load address");
        chk_val({r_we, r_size}, {1'h0, SZ_WORD}, "pc load kind");
        chk_cyc(dn_k, 5, "pc load cycles");
    endtask

    task automatic bx(input logic h2, input logic [2:0] rs,
                      input logic [31:0] tgt, input logic state);
        run(hi(FC_BX, 1'h0, h2, rs, 3'h0), 32'h0, 32'h0);
        chk_val(r_tgt, tgt, "exchange target");
        chk_val(compressed_state_o, state, "new state");
        chk_cyc(br_k, 2, "branch pulse");
        chk_cyc(dn_k, 5, "exchange cycles");
        chk_cyc(fw_k, 0, "exchange keeps flags");
    endtask

    // ------------------------------------------------------------------
    // Main sequence.
    // ------------------------------------------------------------------
    initial begin
        {reset_i, issue_valid_i, instr_i, instr_addr_i} = {2'h2, 48'h0};
        mem_rdata_i = 32'h0;
        error_cnt = 0;
        cmp_count = 0;
        repeat (12) @(negedge core_clk_i);
        chk_val(ready_o, 1'h0, "ready in reset");
        chk_val({compressed_state_o, flags_o}, 5'h10, "state after reset");
        reset_i = 1'h0;
        set_reg(3'h1, 32'h1000, 32'h102, 8'hFF);
        set_reg(3'h2, 32'h20, 32'h100, 8'h00);
        set_reg(3'h3, 32'hA5B6_C7D8, 32'h0, 8'h01);
        set_reg(3'h5, 32'h22, 32'h206, 8'h80);
        set_reg(3'h7, 32'h23, 32'h40, 8'h10);
        peek(3'h3, 32'hA5B6_C7D8);
        $display("Test pc-relative load done");
        st(ls(1'h0, 1'h1, 1'h0, 3'h7, 3'h3), 32'h1023, SZ_BYTE, 32'hD8);
        ld(ls(1'h1, 1'h0, 1'h0, 3'h2, 3'h4), 32'h1122_3344, 32'h1020,
           SZ_WORD, 32'h1122_3344);
        ld(ls(1'h1, 1'h1, 1'h0, 3'h7, 3'h6), 32'h9A44_5566, 32'h1023,
           SZ_BYTE, 32'h9A);
        $display("Test register offset done");
        st(ls(1'h0, 1'h0, 1'h1, 3'h5, 3'h3), 32'h1022, SZ_HALF, 32'hC7D8);
        ld(ls(1'h1, 1'h0, 1'h1, 3'h5, 3'h4), 32'h8765_4321, 32'h1022,
           SZ_HALF, 32'h8765);
        ld(ls(1'h0, 1'h1, 1'h1, 3'h7, 3'h6), 32'hF1E2_D3C4, 32'h1023,
           SZ_BYTE, 32'hFFFF_FFF1);
        ld(ls(1'h1, 1'h1, 1'h1, 3'h5, 3'h4), 32'h8765_4321, 32'h1022,
           SZ_HALF, 32'hFFFF_8765);
        $display("Test sign extend group done");
        run(hi(FC_MOV, 1'h1, 1'h0, 3'h3, 3'h0), 32'h0, 32'h0);
        chk_cyc(dn_k, 3, "move cycles");
        chk_cyc(fw_k, 0, "move keeps flags");
        run(hi(FC_CMP, 1'h1, 1'h0, 3'h3, 3'h0), 32'h0, 32'h0);
        chk_cyc(fw_k, 2, "compare flag pulse");
        chk_val(r_flags, nzcv(32'hA5B6_C7D8, 32'hA5B6_C7D8), "eq flags");
        run(hi(FC_CMP, 1'h1, 1'h0, 3'h2, 3'h0), 32'h0, 32'h0);
        chk_val(r_flags, nzcv(32'hA5B6_C7D8, 32'h20), "neg flags");
        chk_cyc(dn_k, 3, "compare cycles");
        run(hi(FC_MOV, 1'h0, 1'h1, 3'h0, 3'h6), 32'h0, 32'h0);
        run(hi(FC_ADD, 1'h0, 1'h1, 3'h0, 3'h6), 32'h0, 32'h0);
        chk_cyc(fw_k, 0, "add keeps flags");
        chk_val(flags_o, nzcv(32'hA5B6_C7D8, 32'h20), "flags held");
        peek(3'h6, 32'h4B6D_8FB0);
        run(hi(FC_MOV, 1'h0, 1'h1, 3'h7, 3'h0), 32'h203, 32'h0);
        peek(3'h0, 32'h206);
        bx(1'h1, 3'h0, 32'hA5B6_C7D8, 1'h0);
        bx(1'h0, 3'h7, 32'h22, 1'h1);
        bx(1'h1, 3'h7, 32'h4, 1'h0);
        run(hi(FC_MOV, 1'h1, 1'h0, 3'h7, 3'h7), 32'h0, 32'h0);
        chk_val(r_tgt, 32'h22, "move to pc target");
        chk_cyc(br_k, 2, "move to pc branch");
        chk_cyc(dn_k, 5, "pc write cycles");
        $display("Test hi-register group done");
        for (int i = 0; i < 5; i++) begin
            run(i < 3 ? hi(2'(i), 1'h0, 1'h0, 3'h1, 3'h1) :
                i == 3 ? hi(FC_BX, 1'h1, 1'h0, 3'h1, 3'h0) : 16'h0000,
                32'h0, 32'h0);
            chk_val(r_undef, 1'h1, "undefined flag");
            chk_cyc(rq_k + br_k + fw_k, 0, "undefined effect");
            chk_cyc(dn_k, 3, "undefined cycles");
        end
        peek(3'h1, 32'h1000);
        $display("Test undefined encodings done");
        end_sim();
    end
endmodule // cid_exec_tb_top
`default_nettype wire
